// >>> cer_map.vh
// Constants for the configurable embedded RAM family
`ifndef CER_MAP_VH
`define CER_MAP_VH

`define CER_VAR_SMALL     0
`define CER_VAR_MEDIUM    1
`define CER_VAR_LARGE     2

`define CER_MODE_SP       0
`define CER_MODE_SDP      1
`define CER_MODE_TDP      2
`define CER_MODE_ROM      3
`define CER_MODE_FIFO     4
`define CER_MODE_SHIFT    5

`define CER_SMALL_DEPTH   32
`define CER_SMALL_WIDTH   18
`define CER_MEDIUM_DEPTH  128
`define CER_MEDIUM_WIDTH  36
`define CER_LARGE_DEPTH   4096
`define CER_LARGE_WIDTH   144

`define CER_SMALL_BITS    576
`define CER_MEDIUM_BITS   4608

`define CER_LANE_W        9
`define CER_LINK_W        16

`define CER_OUT_CLR_BIT   1'h0
`define CER_RDW_FILL_BIT  1'h1
`define CER_INIT_SEED     32'h00000000

`endif

// >>> cer_out_stage.v
// Per-port output register with bypass and immediate asynchronous clear
`timescale 1ns/1ps
`default_nettype none
`include "cer_map.vh"

module cer_out_stage #(
    parameter WIDTH   = 36,
    parameter REG_OUT = 1
) (
    input  wire             clk,
    input  wire             reset_n,
    input  wire             outClr,
    input  wire             capEn,
    input  wire [WIDTH-1:0] rawData,
    output wire [WIDTH-1:0] dataOut
);
    reg  [WIDTH-1:0] stage_r;
    // Clear acts without a clock, so a registered output drops at once; in bypass it has no effect
    wire             stageRst = ~reset_n | outClr;

    always @(posedge clk or posedge stageRst) begin
        if (stageRst) begin
            stage_r <= {WIDTH{`CER_OUT_CLR_BIT}};
        end else if (capEn) begin
            stage_r <= rawData;
        end
    end

    assign dataOut = (REG_OUT != 0) ? stage_r : rawData;
endmodule // cer_out_stage

`default_nettype wire

// >>> cer_ram.v
// Configurable embedded RAM block: small, medium or large variant
`timescale 1ns/1ps
`default_nettype none
`include "cer_map.vh"

// Notes on behaviour
// - Variants do RAM, FIFO, parity width; ROM on small/medium only
// - Small: 576 bits, no true dual-port
// - Small write regs share one clock
// - Small read side may use either clock
// - Small has read/write and input/output modes
// - Only data output register may be bypassed
// - Medium: 4608 bits, true dual-port capable
// - Medium port B registers use either clock; port A registers stay on clock A
// - Medium ports have separate clock, enable, clear
// - Small/medium contents preload from init image
// - Input clear immediate, output changes next edge
// - Output clear shows at registered output immediately
// - Sixteen direct inputs from each side
// - Large is synchronous, all inputs registered
// - Large contents undefined after power-up
module cer_ram #(
    parameter VARIANT   = `CER_VAR_MEDIUM,
    parameter MODE      = `CER_MODE_SDP,
    parameter REG_OUT_A = 1,
    parameter REG_OUT_B = 1,
    parameter B_CLK_SEL = 1,
    parameter OUT_CLK_SEL = 1,
    parameter OLD_DATA  = 0,
    parameter INIT_EN   = 1,
    // Shape follows the variant; the port list needs it before the body
    parameter DEPTH     = (VARIANT == `CER_VAR_SMALL)  ? `CER_SMALL_DEPTH :
                          (VARIANT == `CER_VAR_MEDIUM) ? `CER_MEDIUM_DEPTH : `CER_LARGE_DEPTH,
    parameter WIDTH     = (VARIANT == `CER_VAR_SMALL)  ? `CER_SMALL_WIDTH :
                          (VARIANT == `CER_VAR_MEDIUM) ? `CER_MEDIUM_WIDTH : `CER_LARGE_WIDTH,
    parameter ADDR_W    = $clog2(DEPTH),
    parameter LANES     = WIDTH / `CER_LANE_W
) (
    input  wire                                   clk,
    input  wire                                   reset_n,
    input  wire                                   clockEnA,
    input  wire                                   clockEnB,
    input  wire                                   inClrA,
    input  wire                                   inClrB,
    input  wire                                   outClrA,
    input  wire                                   outClrB,
    input  wire                                   weA,
    input  wire [ADDR_W-1:0]                      addrA,
    input  wire [WIDTH-1:0]                       wrDataA,
    input  wire [LANES-1:0]                       byteEnA,
    input  wire                                   linkSelA,
    input  wire [`CER_LINK_W-1:0]                 leftLink,
    input  wire [`CER_LINK_W-1:0]                 rightLink,
    input  wire                                   weB,
    input  wire                                   reB,
    input  wire [ADDR_W-1:0]                      addrB,
    input  wire [WIDTH-1:0]                       wrDataB,
    input  wire [LANES-1:0]                       byteEnB,
    output wire [WIDTH-1:0]                       rdDataA,
    output wire [WIDTH-1:0]                       rdDataB,
    output wire                                   fifoFull,
    output wire                                   fifoEmpty,
    output wire                                   initBusy
);
    localparam IS_LARGE = (VARIANT == `CER_VAR_LARGE);

    // Modes a variant lacks fall back to its nearest native form
    localparam EMODE =
        (MODE == `CER_MODE_TDP && VARIANT == `CER_VAR_SMALL) ? `CER_MODE_SDP :
        (MODE == `CER_MODE_ROM && IS_LARGE) ? `CER_MODE_TDP :
        (MODE == `CER_MODE_SHIFT && IS_LARGE) ? `CER_MODE_SDP : MODE;
    localparam KEEP_OLD = (OLD_DATA != 0) && !IS_LARGE;
    localparam DO_INIT  = (INIT_EN != 0) && !IS_LARGE;

    localparam ST_IDLE = 3'h1;
    localparam ST_INIT = 3'h2;
    localparam ST_RUN  = 3'h4;

    function [WIDTH-1:0] mergeLanes;
        input [WIDTH-1:0] oldWord;
        input [WIDTH-1:0] newWord;
        input [LANES-1:0] be;
        integer i;
        begin
            for (i = 0; i < WIDTH; i = i + 1) begin
                mergeLanes[i] = be[i / `CER_LANE_W] ? newWord[i] : oldWord[i];
            end
        end
    endfunction

    function [WIDTH-1:0] padWord;
        input [31:0] src;
        integer i;
        begin
            for (i = 0; i < WIDTH; i = i + 1) begin
                padWord[i] = (i < 32) ? src[i] : 1'h0;
            end
        end
    endfunction

    reg  [WIDTH-1:0]  mem [0:DEPTH-1];
    reg  [2:0]        state_r;
    reg  [2:0]        state_nxt;
    reg  [ADDR_W-1:0] initPtr_r;

    // Port A input registers, all on clock A
    reg               aGo_r;
    reg               aWe_r;
    reg  [ADDR_W-1:0] aAddr_r;
    reg  [WIDTH-1:0]  aData_r;
    reg  [LANES-1:0]  aBe_r;
    // Port B input registers, on the selected clock
    reg               bGo_r;
    reg               bWe_r;
    reg               bRd_r;
    reg  [ADDR_W-1:0] bAddr_r;
    reg  [WIDTH-1:0]  bData_r;
    reg  [LANES-1:0]  bBe_r;

    reg  [WIDTH-1:0]  rawA_r;
    reg  [WIDTH-1:0]  rawB_r;
    reg  [ADDR_W-1:0] wPtr_r;
    reg  [ADDR_W-1:0] rPtr_r;
    reg  [ADDR_W:0]   count_r;

    wire running = (state_r == ST_RUN);
    wire enB     = (B_CLK_SEL != 0) ? clockEnB : clockEnA;
    wire enOut   = (OUT_CLK_SEL != 0) ? clockEnB : clockEnA;
    wire aInRst  = ~reset_n | inClrA;
    wire bInRst  = ~reset_n | inClrB;
    wire [WIDTH-1:0] linkWord = padWord({rightLink, leftLink});

    assign initBusy  = ~running;
    assign fifoFull  = (count_r == DEPTH[ADDR_W:0]);
    assign fifoEmpty = (count_r == {(ADDR_W+1){1'h0}});

    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: state_nxt = DO_INIT ? ST_INIT : ST_RUN;
            ST_INIT: if (initPtr_r == DEPTH[ADDR_W-1:0] - 1'h1) state_nxt = ST_RUN;
            ST_RUN:  state_nxt = ST_RUN;
            default: state_nxt = ST_IDLE;
        endcase
    end

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r   <= ST_IDLE;
            initPtr_r <= {ADDR_W{1'h0}};
        end else begin
            state_r <= state_nxt;
            if (state_r == ST_INIT) begin
                initPtr_r <= initPtr_r + 1'h1;
            end
        end
    end

    // Clear empties the input registers now; memory sees it next edge
    always @(posedge clk or posedge aInRst) begin
        if (aInRst) begin
            aGo_r   <= 1'h0;
            aWe_r   <= 1'h0;
            aAddr_r <= {ADDR_W{1'h0}};
            aData_r <= {WIDTH{1'h0}};
            aBe_r   <= {LANES{1'h0}};
        end else begin
            aGo_r <= clockEnA & running;
            if (clockEnA) begin
                aWe_r   <= weA & (EMODE != `CER_MODE_ROM);
                aAddr_r <= addrA;
                aData_r <= linkSelA ? linkWord : wrDataA;
                aBe_r   <= byteEnA;
            end
        end
    end

    always @(posedge clk or posedge bInRst) begin
        if (bInRst) begin
            bGo_r   <= 1'h0;
            bWe_r   <= 1'h0;
            bRd_r   <= 1'h0;
            bAddr_r <= {ADDR_W{1'h0}};
            bData_r <= {WIDTH{1'h0}};
            bBe_r   <= {LANES{1'h0}};
        end else begin
            bGo_r <= enB & running;
            if (enB) begin
                bWe_r   <= weB & (EMODE == `CER_MODE_TDP);
                bRd_r   <= reB;
                bAddr_r <= addrB;
                bData_r <= wrDataB;
                bBe_r   <= byteEnB;
            end
        end
    end

    wire isFifo  = (EMODE == `CER_MODE_FIFO);
    wire isShift = (EMODE == `CER_MODE_SHIFT);
    wire pushA   = aGo_r & aWe_r & isFifo & ~fifoFull;
    wire popB    = bGo_r & bRd_r & isFifo & ~fifoEmpty;
    wire wrA     = aGo_r & aWe_r & (~isFifo | ~fifoFull);
    wire wrB     = bGo_r & bWe_r;
    wire [ADDR_W-1:0] wAddrA = isFifo ? wPtr_r : (isShift ? rPtr_r : aAddr_r);
    wire rdA     = aGo_r & ~aWe_r & (EMODE == `CER_MODE_SP || EMODE == `CER_MODE_TDP ||
                                     EMODE == `CER_MODE_ROM);
    wire rdB     = bGo_r & bRd_r & ~bWe_r &
                   (EMODE == `CER_MODE_SDP || EMODE == `CER_MODE_TDP);
    wire hitB    = rdB & wrA & (wAddrA == bAddr_r);
    wire hitA    = rdA & wrB & (bAddr_r == aAddr_r);

    // Init walk fills the array before ports are let
    always @(posedge clk) begin
        if (state_r == ST_INIT) begin
            mem[initPtr_r] <= padWord(`CER_INIT_SEED ^ {{(32-ADDR_W){1'h0}}, initPtr_r});
        end else begin
            if (wrA) begin
                mem[wAddrA] <= mergeLanes(mem[wAddrA], aData_r, aBe_r);
            end
            // Same-word double write: port B lands last
            if (wrB) begin
                mem[bAddr_r] <= mergeLanes(mem[bAddr_r], bData_r, bBe_r);
            end
        end
    end

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rawA_r  <= {WIDTH{1'h0}};
            rawB_r  <= {WIDTH{1'h0}};
            wPtr_r  <= {ADDR_W{1'h0}};
            rPtr_r  <= {ADDR_W{1'h0}};
            count_r <= {(ADDR_W+1){1'h0}};
        end else begin
            if (rdA) begin
                rawA_r <= (hitA && !KEEP_OLD) ? {WIDTH{`CER_RDW_FILL_BIT}} : mem[aAddr_r];
            end
            if (rdB) begin
                rawB_r <= (hitB && !KEEP_OLD) ? {WIDTH{`CER_RDW_FILL_BIT}} : mem[bAddr_r];
            end else if (popB) begin
                rawB_r <= mem[rPtr_r];
            end else if (isShift && wrA) begin
                // Tap word leaves one full depth after entering
                rawB_r <= mem[rPtr_r];
            end
            if (pushA) begin
                wPtr_r <= wPtr_r + 1'h1;
            end
            if (popB || (isShift && wrA)) begin
                rPtr_r <= rPtr_r + 1'h1;
            end
            if (pushA && !popB) begin
                count_r <= count_r + 1'h1;
            end else if (popB && !pushA) begin
                count_r <= count_r - 1'h1;
            end
        end
    end

    cer_out_stage #(
        .WIDTH   (WIDTH),
        .REG_OUT (REG_OUT_A)
    ) u_out_a (
        .clk     (clk),
        .reset_n (reset_n),
        .outClr  (outClrA),
        .capEn   (clockEnA),
        .rawData (rawA_r),
        .dataOut (rdDataA)
    );

    cer_out_stage #(
        .WIDTH   (WIDTH),
        .REG_OUT (REG_OUT_B)
    ) u_out_b (
        .clk     (clk),
        .reset_n (reset_n),
        .outClr  (outClrB),
        .capEn   (enOut),
        .rawData (rawB_r),
        .dataOut (rdDataB)
    );
endmodule // cer_ram

`default_nettype wire

// >>> cer_ram_asserts.sv
// Port B output and status flag checks for the embedded RAM
`timescale 1ns/1ps
`default_nettype none
module cer_ram_asserts #(parameter WIDTH = 36) (
    input wire logic             clk,
    input wire logic             reset_n,
    input wire logic             clockEnB,
    input wire logic             reB,
    input wire logic             outClrB,
    input wire logic [WIDTH-1:0] rdDataB,
    input wire logic             fifoFull,
    input wire logic             fifoEmpty,
    input wire logic             initBusy
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    logic [7:0] busyCnt_r;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            busyCnt_r <= 8'h00;
        end else if (initBusy) begin
            busyCnt_r <= busyCnt_r + 8'h01;
        end
    end
    a_clear_zero: assert property (outClrB |-> rdDataB == '0)
        else $error("output not zero under clear");
    a_clear_hold: assert property ($fell(outClrB) |-> rdDataB == '0)
        else $error("output left zero without capture");
    a_idle_stable: assert property (!clockEnB && !outClrB ##1 !outClrB |-> $stable(rdDataB))
        else $error("output moved without enable");
    // Raw flop moves one edge after a taken read, so the first cycle must be read-free
    a_capture_steady: assert property (
        !(clockEnB && reB) ##1 (clockEnB && !reB && !outClrB) [*2] ##1 !outClrB
        |-> $stable(rdDataB))
        else $error("output moved with no read");
    a_init_span: assert property ($fell(initBusy) |-> busyCnt_r inside {[8'h80:8'h82]})
        else $error("preload walk length wrong");
    a_busy_once: assert property (!initBusy |=> !initBusy)
        else $error("preload restarted");
    a_init_flags: assert property (initBusy |-> fifoEmpty && !fifoFull)
        else $error("flags wrong during preload");
    a_flags_excl: assert property (!(fifoFull && fifoEmpty))
        else $error("full and empty together");
    c_init_done: cover property ($fell(initBusy));
    c_read: cover property (clockEnB && reB);
    c_clear: cover property ($fell(outClrB));
endmodule // cer_ram_asserts
bind cer_ram cer_ram_asserts #(.WIDTH(WIDTH)) chk_u (.clk(clk), .reset_n(reset_n),
    .clockEnB(clockEnB), .reB(reB), .outClrB(outClrB), .rdDataB(rdDataB),
    .fifoFull(fifoFull), .fifoEmpty(fifoEmpty), .initBusy(initBusy));
`default_nettype wire

// >>> cer_fabric_model.sv
// Fabric-side user logic driving the RAM ports
`timescale 1ns/1ps
`default_nettype none
module cer_fabric_model (
    input  wire logic        clk,
    input  wire logic [35:0] rdDataB,
    output var  logic        clockEnA = 1'h0,
    output var  logic        weA = 1'h0,
    output var  logic [6:0]  addrA = 7'h00,
    output var  logic [35:0] wrDataA = 36'h0,
    output var  logic [3:0]  byteEnA = 4'h0,
    output var  logic        linkSelA = 1'h0,
    output var  logic [15:0] leftLink = 16'h0,
    output var  logic [15:0] rightLink = 16'h0,
    output var  logic        clockEnB = 1'h0,
    output var  logic        reB = 1'h0,
    output var  logic [6:0]  addrB = 7'h00
);
    // Held past the take edge so callers can issue writes back to back
    task automatic wr(input logic [6:0] a, input logic [35:0] d, input logic [3:0] be,
                      input logic lk);
        @(negedge clk);
        clockEnA = 1'h1;
        weA = 1'h1;
        addrA = a;
        wrDataA = lk ? ~d : d;
        byteEnA = be;
        linkSelA = lk;
        leftLink = d[15:0];
        rightLink = d[31:16];
        @(posedge clk);
    endtask
    task automatic endA();
        @(negedge clk);
        clockEnA = 1'h0;
        weA = 1'h0;
        addrA = ~addrA;
        wrDataA = ~wrDataA;
    endtask
    task automatic rd(input logic [6:0] a, output logic [35:0] q);
        @(negedge clk);
        clockEnB = 1'h1;
        reB = 1'h1;
        addrB = a;
        @(negedge clk);
        reB = 1'h0;
        addrB = ~a;
        repeat (2) @(negedge clk);
        q = rdDataB;
        @(negedge clk);
        clockEnB = 1'h0;
    endtask
endmodule // cer_fabric_model
`default_nettype wire

// >>> cer_ram_bench.sv
// Self-checking bench: medium RAM in simple dual-port mode
`timescale 1ns/1ps
`default_nettype none
module cer_ram_bench;
    logic        clk = 1'h0;
    logic        reset_n = 1'h0;
    logic        inClrB = 1'h0;
    logic        outClrB = 1'h0;
    int          mismatches = 0;
    int          cmp_count = 0;
    int          cyc = 0;
    logic [35:0] q;
    wire         clockEnA, weA, linkSelA, clockEnB, reB, fifoFull, fifoEmpty, initBusy;
    wire [6:0]   addrA, addrB;
    wire [35:0]  wrDataA, rdDataA, rdDataB;
    wire [3:0]   byteEnA;
    wire [15:0]  leftLink, rightLink;
    always #2.5 clk = ~clk;
    cer_ram dut_u (.clk(clk), .reset_n(reset_n), .clockEnA(clockEnA), .clockEnB(clockEnB),
        .inClrA(1'h0), .inClrB(inClrB), .outClrA(1'h0), .outClrB(outClrB), .weA(weA),
        .addrA(addrA), .wrDataA(wrDataA), .byteEnA(byteEnA), .linkSelA(linkSelA),
        .leftLink(leftLink), .rightLink(rightLink), .weB(1'h0), .reB(reB), .addrB(addrB),
        .wrDataB(36'h0), .byteEnB(4'h0), .rdDataA(rdDataA), .rdDataB(rdDataB),
        .fifoFull(fifoFull), .fifoEmpty(fifoEmpty), .initBusy(initBusy));
    cer_fabric_model fab_u (.clk(clk), .rdDataB(rdDataB), .clockEnA(clockEnA), .weA(weA),
        .addrA(addrA), .wrDataA(wrDataA), .byteEnA(byteEnA), .linkSelA(linkSelA),
        .leftLink(leftLink), .rightLink(rightLink), .clockEnB(clockEnB), .reB(reB),
        .addrB(addrB));
    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic t_init();
        chk({35'h0, initBusy}, 36'h1);
        chk({35'h0, fifoEmpty}, 36'h1);
        for (int i = 0; i < 200 && initBusy !== 1'h0; i++)
            @(negedge clk);
        for (int a = 0; a < 128; a += 63) begin
            fab_u.rd(a[6:0], q);
            chk(q, 36'(a));
        end
    endtask
    task automatic t_writes();
        fab_u.wr(7'h0A, 36'h0, 4'hF, 1'h0);
        fab_u.wr(7'h0A, 36'hFFFFFFFFF, 4'h5, 1'h0);
        for (int a = 20; a < 24; a++)
            fab_u.wr(a[6:0], 36'hA5A5A5A50 + 36'(a), 4'hF, 1'h0);
        fab_u.wr(7'h28, 36'h9ABCD1234, 4'hF, 1'h1);
        fab_u.endA();
        fab_u.rd(7'h0A, q);
        chk(q, 36'h007FC01FF);
        for (int a = 20; a < 24; a++) begin
            fab_u.rd(a[6:0], q);
            chk(q, 36'hA5A5A5A50 + 36'(a));
        end
        fab_u.rd(7'h28, q);
        chk(q, 36'h0ABCD1234);
        // Write-only port A never loads its read side
        chk(rdDataA, 36'h0);
    endtask
    task automatic t_collide();
        fork
            fab_u.wr(7'h1E, 36'h123456789, 4'hF, 1'h0);
            fab_u.rd(7'h1E, q);
        join
        chk(q, 36'hFFFFFFFFF);
        fab_u.endA();
        fab_u.rd(7'h1E, q);
        chk(q, 36'h123456789);
    endtask
    task automatic t_clears();
        fab_u.rd(7'h05, q);
        @(negedge clk);
        outClrB = 1'h1;
        #1 chk(rdDataB, 36'h0);
        @(negedge clk);
        outClrB = 1'h0;
        @(negedge clk);
        chk(rdDataB, 36'h0);
        inClrB = 1'h1;
        fab_u.rd(7'h06, q);
        chk(q, 36'h5);
        inClrB = 1'h0;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            mismatches++;
            stop_test();
        end
    end
    initial begin
        repeat (5) @(negedge clk);
        reset_n = 1'h1;
        t_init();
        t_writes();
        t_collide();
        t_clears();
        stop_test();
    end
endmodule // cer_ram_bench
`default_nettype wire
